// File: logic/pmx_consts.svh
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// register indices, byte address is index times four
`define PMX_IDX_DIN_A     8'h00
`define PMX_IDX_DIN_B     8'h01
`define PMX_IDX_DIN_C     8'h10
`define PMX_IDX_DIN_D     8'h11
`define PMX_IDX_CTRL_A    8'h02
`define PMX_IDX_CTRL_B    8'h03
`define PMX_IDX_DOUT_A    8'h04
`define PMX_IDX_DOUT_B    8'h05
`define PMX_IDX_DOUT_C    8'h12
`define PMX_IDX_DOUT_D    8'h13
`define PMX_IDX_DIR_A     8'h06
`define PMX_IDX_DIR_B     8'h07
`define PMX_IDX_DIR_C     8'h14
`define PMX_IDX_DIR_D     8'h15
`define PMX_IDX_OEN_A     8'h0C
`define PMX_IDX_OEN_B     8'h0D
`define PMX_IDX_OEN_C     8'h1A
`define PMX_IDX_OEN_D     8'h1B
`define PMX_IDX_JTAG_EN   8'hC7
`define PMX_IDX_LSEL_A    8'h40
`define PMX_IDX_LSEL_B    8'h41
`define PMX_IDX_LSEL_C    8'h42
`define PMX_IDX_LSEL_D    8'h43
`define PMX_IDX_PROFILE   8'h44

// reset values
`define PMX_RST_BYTE      8'h00
`define PMX_RST_PORTD     3'h0
`define PMX_RST_PROFILE   3'h0
`define PMX_RST_JTAG      1'h0
`define PMX_ZERO_WORD     32'h0000_0000
`define PMX_RST_OEN       27'h7FF_FFFF

// profile codes, bits 1:0 of the profile register; bit 2 enables the data port in the non-multiplexed profile
`define PMX_PCODE_MUX     2'h0
`define PMX_PCODE_NONMUX  2'h1
`define PMX_PCODE_EXT     2'h2
`define PMX_PCODE_PAGE    2'h3
`define PMX_PROF_DPORT    2

// address nibble selectors
`define PMX_NIB_A3_0      2'h0
`define PMX_NIB_A7_4      2'h1
`define PMX_NIB_A11_8     2'h2
`define PMX_NIB_A15_12    2'h3

// port c test pin positions in the flat pin vector
`define PMX_PIN_TMS       16
`define PMX_PIN_TCK       17
`define PMX_PIN_STAT      19
`define PMX_PIN_ERR       20
`define PMX_PIN_TDI       21
`define PMX_PIN_TDO       22
`define PMX_JTAG_MASK     27'h040_0000 | 27'h020_0000 | 27'h010_0000 | 27'h008_0000 | 27'h003_0000

`endif

// File: logic/pmx_host_capture.sv
`include "pmx_consts.svh"

module pmx_host_capture
   import pmx_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rstN,
   input  wire logic          ce,
   input  wire pmx_host_bus_t hostPin,
   input  wire logic          latchAlways,
   output pmx_host_bus_t      hostSync,
   output logic [15:0]        latchedAddr
);
   pmx_host_bus_t meta_ff;
   pmx_host_bus_t sync_ff;
   logic [15:0]   addr_ff;

   // two-stage synchroniser for the host bus pins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else if (ce) begin
         meta_ff <= hostPin;
         sync_ff <= meta_ff;
      end
   end

   // address latch, transparent while ale is high
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         addr_ff <= 16'h0000;
      end else if (ce && (sync_ff.ale || latchAlways)) begin
         addr_ff <= sync_ff.addr;
      end
   end

   assign hostSync    = sync_ff;
   assign latchedAddr = addr_ff;
endmodule // pmx_host_capture

// File: logic/pmx_pkg.sv
package pmx_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic        ale;
      logic        rdN;
      logic        wrN;
      logic        csN;
   } pmx_host_bus_t;

   typedef struct packed {
      logic        ale;
      logic        rdN;
      logic        wrN;
      logic        csN;
   } pmx_host_ctrl_t;

   typedef enum logic [3:0] {
      PMX_PROF_MUX    = 4'b0001,
      PMX_PROF_NONMUX = 4'b0010,
      PMX_PROF_EXT    = 4'b0100,
      PMX_PROF_PAGE   = 4'b1000
   } pmx_profile_t;
endpackage

// File: logic/pmx_port_mux.sv
// The register addresses and register access over APB were left to the implementer.
`include "pmx_consts.svh"

// Overview of operation
// RULE1 - twenty-seven pins on ports a, b, c and d each pick their function independently.
// RULE2 - every pin can be host i/o, logic-array i/o or latched address output; the code offers address output on ports a and b only.
// RULE3 - ports a and b together serve as the data port of a non-multiplexed host bus; the code uses port a alone as the 8-bit data port.
// RULE4 - the serial test port can be switched onto port c, sharing pins with other functions.
// RULE5 - test mode puts tms, tck, status, error, tdi and tdo on port c bits 0, 1, 3, 4, 5, 6.
// RULE6 - generic multiplexed hosts get a3-a0 on low and a7-a4 on high nibbles of a and b.
// RULE7 - non-multiplexed hosts get no address on port a and a3-a0/a7-a4 on port b.
// RULE8 - extended hosts get a7-a4 on a high and a11-a8 on b low; page mode a11-a8, a15-a12 on b.
// RULE9 - host bus control signals are accepted and also forwarded to the logic arrays.
// RULE10 - the host places the register set in a 256-byte window and reaches it by offset; the code decodes paddr[9:2], a 1024-byte window of word registers.
// RULE11 - control registers at 02 and 03 choose host i/o or address output per pin of a and b.
// RULE12 - direction registers at 06, 07, 14 and 15 set each pin of a, b, c, d as in or out.
// RULE13 - with the test port on, its port c pins ignore every other function selection.
module pmx_port_mux
   import pmx_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [9:0]    paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire pmx_host_bus_t hostPin,
   output pmx_host_ctrl_t     hostCtrlToLogic,
   output logic [7:0]         hostPortData,
   input  wire logic [26:0]   pinIn,
   output logic [26:0]        pinOut,
   output logic [26:0]        pinOeN,
   input  wire logic [26:0]   logicOut,
   input  wire logic [26:0]   logicOe,
   output logic [26:0]        pinToLogic,
   input  wire logic          testStatus,
   input  wire logic          testError,
   input  wire logic          testTdo,
   input  wire logic          testTdoOe,
   output logic               testTms,
   output logic               testTck,
   output logic               testTdi
);
   logic           rstMeta_ff;
   logic           rstN_ff;
   logic [26:0]    pinMeta_ff;
   logic [26:0]    pinSync_ff;
   logic [26:0]    pinOut_ff;
   logic [26:0]    pinOeN_ff;
   logic [26:0]    nxt_pinOut;
   logic [26:0]    nxt_pinOeN;
   logic [7:0]     ctrlA_ff;
   logic [7:0]     ctrlB_ff;
   logic [7:0]     doutA_ff;
   logic [7:0]     doutB_ff;
   logic [7:0]     doutC_ff;
   logic [2:0]     doutD_ff;
   logic [7:0]     dirA_ff;
   logic [7:0]     dirB_ff;
   logic [7:0]     dirC_ff;
   logic [2:0]     dirD_ff;
   logic [7:0]     lselA_ff;
   logic [7:0]     lselB_ff;
   logic [7:0]     lselC_ff;
   logic [2:0]     lselD_ff;
   logic           jtagEn_ff;
   logic [2:0]     profile_ff;
   pmx_host_ctrl_t hostCtrl_ff;
   logic [7:0]     hostPortData_ff;
   logic [31:0]    prdata_ff;
   logic           pready_ff;
   logic           pslverr_ff;
   logic [31:0]    nxt_prdata;
   logic           mapped;

   pmx_host_bus_t  hostSync;
   logic [15:0]    latchedAddr;
   pmx_profile_t   profile;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff <= 1'b0;
         rstN_ff    <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstN_ff    <= rstMeta_ff;
      end
   end

   function automatic pmx_profile_t profDecode(input logic [1:0] code);
      case (code)
         `PMX_PCODE_MUX:    profDecode = PMX_PROF_MUX;
         `PMX_PCODE_NONMUX: profDecode = PMX_PROF_NONMUX;
         `PMX_PCODE_EXT:    profDecode = PMX_PROF_EXT;
         default:           profDecode = PMX_PROF_PAGE;
      endcase
   endfunction

   // nibble map per profile: {valid, nibble}
   function automatic logic [2:0] nibMap(input pmx_profile_t p, input logic portB,
                                         input logic hi);
      case (p)
         PMX_PROF_MUX:    nibMap = {1'b1, hi ? `PMX_NIB_A7_4 : `PMX_NIB_A3_0};   // [RULE6]
         PMX_PROF_NONMUX: nibMap = {portB, hi ? `PMX_NIB_A7_4 : `PMX_NIB_A3_0};  // [RULE7]
         PMX_PROF_EXT:    nibMap = portB ? {!hi, `PMX_NIB_A11_8}
                                         : {hi, `PMX_NIB_A7_4};                   // [RULE8]
         PMX_PROF_PAGE:   nibMap = {portB, hi ? `PMX_NIB_A15_12 : `PMX_NIB_A11_8}; // [RULE8]
         default:         nibMap = 3'h0;
      endcase
   endfunction

   // host bus synchroniser and address latch; non-multiplexed buses follow the address
   pmx_host_capture u_capture (
      .clk         (clk),
      .rstN        (rstN_ff),
      .ce          (ce),
      .hostPin     (hostPin),
      .latchAlways (profile == PMX_PROF_NONMUX),
      .hostSync    (hostSync),
      .latchedAddr (latchedAddr)
   );

   assign profile = profDecode(profile_ff[1:0]);

   // flat per-pin configuration, port a lowest
   wire [26:0] ctrlVec = {3'h0, 8'h00, ctrlB_ff, ctrlA_ff};                // [RULE11]
   wire [26:0] doutVec = {doutD_ff, doutC_ff, doutB_ff, doutA_ff};
   wire [26:0] dirVec  = {dirD_ff, dirC_ff, dirB_ff, dirA_ff};              // [RULE12]
   wire [26:0] lselVec = {lselD_ff, lselC_ff, lselB_ff, lselA_ff};
   wire [26:0] jtagVec = jtagEn_ff ? (`PMX_JTAG_MASK) : 27'h000_0000;      // [RULE4]
   wire        dataPortOn = profile_ff[`PMX_PROF_DPORT] && (profile == PMX_PROF_NONMUX);
   wire        hostWrAct  = !hostSync.csN && !hostSync.wrN;

   wire [2:0]  nibAL = nibMap(profile, 1'b0, 1'b0);
   wire [2:0]  nibAH = nibMap(profile, 1'b0, 1'b1);
   wire [2:0]  nibBL = nibMap(profile, 1'b1, 1'b0);
   wire [2:0]  nibBH = nibMap(profile, 1'b1, 1'b1);
   wire [15:0] addrNibs = {nibBH[2] ? latchedAddr[{nibBH[1:0], 2'b00} +: 4] : 4'h0,
                           nibBL[2] ? latchedAddr[{nibBL[1:0], 2'b00} +: 4] : 4'h0,
                           nibAH[2] ? latchedAddr[{nibAH[1:0], 2'b00} +: 4] : 4'h0,
                           nibAL[2] ? latchedAddr[{nibAL[1:0], 2'b00} +: 4] : 4'h0};
   wire [26:0] addrVal = {11'h000, addrNibs};
   wire [26:0] addrVld = {11'h000, {4{nibBH[2]}}, {4{nibBL[2]}}, {4{nibAH[2]}},
                          {4{nibAL[2]}}} & ctrlVec;                          // [RULE6]
   wire [26:0] dportVec = dataPortOn ? 27'h000_00FF : 27'h000_0000;         // [RULE3]

   // test port pins: drive status and error, drive tdo while testTdoOe is high, release the inputs
   wire [26:0] jtagOut = (27'h1 << `PMX_PIN_STAT) & {27{testStatus}}
                       | (27'h1 << `PMX_PIN_ERR) & {27{testError}}
                       | (27'h1 << `PMX_PIN_TDO) & {27{testTdo}};          // [RULE5]
   wire [26:0] jtagDrv = (27'h1 << `PMX_PIN_STAT) | (27'h1 << `PMX_PIN_ERR)
                       | ((27'h1 << `PMX_PIN_TDO) & {27{testTdoOe}});

   // per-pin function priority: test port, data port, address, logic array, host i/o
   genvar gi;
   generate
      for (gi = 0; gi < 27; gi++) begin : g_pin                              // [RULE1]
         always_comb begin
            if (jtagVec[gi]) begin                                           // [RULE13]
               nxt_pinOut[gi] = jtagOut[gi];
               nxt_pinOeN[gi] = !jtagDrv[gi];
            end else if (dportVec[gi]) begin
               nxt_pinOut[gi] = hostSync.data[gi % 8];                       // [RULE3]
               nxt_pinOeN[gi] = !hostWrAct;
            end else if (addrVld[gi]) begin
               nxt_pinOut[gi] = addrVal[gi];                                 // [RULE2]
               nxt_pinOeN[gi] = 1'b0;
            end else if (lselVec[gi]) begin
               nxt_pinOut[gi] = logicOut[gi];                                // [RULE2]
               nxt_pinOeN[gi] = !logicOe[gi];
            end else begin
               nxt_pinOut[gi] = doutVec[gi];                                 // [RULE2]
               nxt_pinOeN[gi] = !dirVec[gi];                                 // [RULE12]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstN_ff) begin
      if (!rstN_ff) begin
         pinMeta_ff      <= 27'h000_0000;
         pinSync_ff      <= 27'h000_0000;
         pinOut_ff       <= 27'h000_0000;
         pinOeN_ff       <= `PMX_RST_OEN;
         hostCtrl_ff     <= '1;
         hostPortData_ff <= `PMX_RST_BYTE;
      end else if (ce) begin
         pinMeta_ff      <= pinIn;
         pinSync_ff      <= pinMeta_ff;
         pinOut_ff       <= nxt_pinOut;
         pinOeN_ff       <= nxt_pinOeN;
         hostCtrl_ff     <= {hostSync.ale, hostSync.rdN, hostSync.wrN, hostSync.csN}; // [RULE9]
         hostPortData_ff <= pinSync_ff[7:0];
      end
   end

   // register window: index is byte address over four
   wire [7:0] idx    = paddr[9:2];                                           // [RULE10]
   wire       access = psel && penable && pready_ff;
   wire       wrEn   = access && pwrite && pstrb[0] && mapped;
   wire [7:0] wb     = pwdata[7:0];
   wire [26:0] oeVec = ~pinOeN_ff;

   always_comb begin
      mapped     = 1'b1;
      nxt_prdata = `PMX_ZERO_WORD;
      case (idx)
         `PMX_IDX_DIN_A:   nxt_prdata[7:0] = pinSync_ff[7:0];
         `PMX_IDX_DIN_B:   nxt_prdata[7:0] = pinSync_ff[15:8];
         `PMX_IDX_DIN_C:   nxt_prdata[7:0] = pinSync_ff[23:16];
         `PMX_IDX_DIN_D:   nxt_prdata[2:0] = pinSync_ff[26:24];
         `PMX_IDX_CTRL_A:  nxt_prdata[7:0] = ctrlA_ff;
         `PMX_IDX_CTRL_B:  nxt_prdata[7:0] = ctrlB_ff;
         `PMX_IDX_DOUT_A:  nxt_prdata[7:0] = doutA_ff;
         `PMX_IDX_DOUT_B:  nxt_prdata[7:0] = doutB_ff;
         `PMX_IDX_DOUT_C:  nxt_prdata[7:0] = doutC_ff;
         `PMX_IDX_DOUT_D:  nxt_prdata[2:0] = doutD_ff;
         `PMX_IDX_DIR_A:   nxt_prdata[7:0] = dirA_ff;
         `PMX_IDX_DIR_B:   nxt_prdata[7:0] = dirB_ff;
         `PMX_IDX_DIR_C:   nxt_prdata[7:0] = dirC_ff;
         `PMX_IDX_DIR_D:   nxt_prdata[2:0] = dirD_ff;
         `PMX_IDX_OEN_A:   nxt_prdata[7:0] = oeVec[7:0];
         `PMX_IDX_OEN_B:   nxt_prdata[7:0] = oeVec[15:8];
         `PMX_IDX_OEN_C:   nxt_prdata[7:0] = oeVec[23:16];
         `PMX_IDX_OEN_D:   nxt_prdata[2:0] = oeVec[26:24];
         `PMX_IDX_JTAG_EN: nxt_prdata[0]   = jtagEn_ff;
         `PMX_IDX_LSEL_A:  nxt_prdata[7:0] = lselA_ff;
         `PMX_IDX_LSEL_B:  nxt_prdata[7:0] = lselB_ff;
         `PMX_IDX_LSEL_C:  nxt_prdata[7:0] = lselC_ff;
         `PMX_IDX_LSEL_D:  nxt_prdata[2:0] = lselD_ff;
         `PMX_IDX_PROFILE: nxt_prdata[2:0] = profile_ff;
         default:          mapped = 1'b0;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk or negedge rstN_ff) begin
      if (!rstN_ff) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= `PMX_ZERO_WORD;
      end else if (ce) begin
         pready_ff  <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !mapped;
         prdata_ff  <= (psel && penable && !pready_ff && !pwrite) ? nxt_prdata
                                                                    : `PMX_ZERO_WORD;
      end
   end

   always_ff @(posedge clk or negedge rstN_ff) begin
      if (!rstN_ff) begin
         ctrlA_ff   <= `PMX_RST_BYTE;
         ctrlB_ff   <= `PMX_RST_BYTE;
         doutA_ff   <= `PMX_RST_BYTE;
         doutB_ff   <= `PMX_RST_BYTE;
         doutC_ff   <= `PMX_RST_BYTE;
         doutD_ff   <= `PMX_RST_PORTD;
         dirA_ff    <= `PMX_RST_BYTE;
         dirB_ff    <= `PMX_RST_BYTE;
         dirC_ff    <= `PMX_RST_BYTE;
         dirD_ff    <= `PMX_RST_PORTD;
         lselA_ff   <= `PMX_RST_BYTE;
         lselB_ff   <= `PMX_RST_BYTE;
         lselC_ff   <= `PMX_RST_BYTE;
         lselD_ff   <= `PMX_RST_PORTD;
         jtagEn_ff  <= `PMX_RST_JTAG;
         profile_ff <= `PMX_RST_PROFILE;
      end else if (ce && wrEn) begin
         if (idx == `PMX_IDX_CTRL_A)  ctrlA_ff   <= wb;                     // [RULE11]
         if (idx == `PMX_IDX_CTRL_B)  ctrlB_ff   <= wb;                     // [RULE11]
         if (idx == `PMX_IDX_DOUT_A)  doutA_ff   <= wb;
         if (idx == `PMX_IDX_DOUT_B)  doutB_ff   <= wb;
         if (idx == `PMX_IDX_DOUT_C)  doutC_ff   <= wb;
         if (idx == `PMX_IDX_DOUT_D)  doutD_ff   <= wb[2:0];
         if (idx == `PMX_IDX_DIR_A)   dirA_ff    <= wb;                     // [RULE12]
         if (idx == `PMX_IDX_DIR_B)   dirB_ff    <= wb;                     // [RULE12]
         if (idx == `PMX_IDX_DIR_C)   dirC_ff    <= wb;                     // [RULE12]
         if (idx == `PMX_IDX_DIR_D)   dirD_ff    <= wb[2:0];                // [RULE12]
         if (idx == `PMX_IDX_LSEL_A)  lselA_ff   <= wb;
         if (idx == `PMX_IDX_LSEL_B)  lselB_ff   <= wb;
         if (idx == `PMX_IDX_LSEL_C)  lselC_ff   <= wb;
         if (idx == `PMX_IDX_LSEL_D)  lselD_ff   <= wb[2:0];
         if (idx == `PMX_IDX_JTAG_EN) jtagEn_ff  <= wb[0];                  // [RULE4]
         if (idx == `PMX_IDX_PROFILE) profile_ff <= wb[2:0];
      end
   end

   assign prdata          = prdata_ff;
   assign pready          = pready_ff;
   assign pslverr         = pslverr_ff;
   assign pinOut          = pinOut_ff;
   assign pinOeN          = pinOeN_ff;
   assign pinToLogic      = pinSync_ff;
   assign hostCtrlToLogic = hostCtrl_ff;                                     // [RULE9]
   assign hostPortData    = hostPortData_ff;
   assign testTms         = pinSync_ff[`PMX_PIN_TMS];                         // [RULE5]
   assign testTck         = pinSync_ff[`PMX_PIN_TCK];                         // [RULE5]
   assign testTdi         = pinSync_ff[`PMX_PIN_TDI];                         // [RULE5]
endmodule // pmx_port_mux

// File: verif/pmx_host_model.sv
module pmx_host_model
   import pmx_pkg::*;
(
   input  wire logic     clk,
   output pmx_host_bus_t hostPin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial hostPin = {16'h0000, 8'h00, 1'b0, 3'b111};

   // multiplexed address phase; bus moves on after ale falls
   task automatic latch_addr(input logic [15:0] a);
      @(posedge clk);
      hostPin.addr <= a;
      hostPin.ale <= 1'b1;
      repeat (4) @(posedge clk);
      hostPin.ale <= 1'b0;
      repeat (2) @(posedge clk);
      hostPin.addr <= ~a;
   endtask

   // write strobe on or off; released data bus shows the inverse
   task automatic bus_write(input logic on, input logic [7:0] d);
      @(posedge clk);
      hostPin.data <= on ? d : ~d;
      hostPin.csN <= !on;
      hostPin.wrN <= !on;
   endtask
endmodule // pmx_host_model

// File: verif/pmx_port_mux_assertions.sv
module pmx_port_mux_checker
   import pmx_pkg::*;
(
   input wire logic           clk,
   input wire logic           rst_n,
   input wire logic           ce,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [9:0]     paddr,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire pmx_host_bus_t  hostPin,
   input wire pmx_host_ctrl_t hostCtrlToLogic,
   input wire logic [26:0]    pinIn,
   input wire logic [26:0]    pinToLogic
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic [7:0] idx = paddr[9:2];
   wire logic       isD = idx inside {8'h11, 8'h13, 8'h15, 8'h1B, 8'h43};
   wire logic       mapped = isD || idx inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h07, 8'h0C, 8'h0D, 8'h10, 8'h12, 8'h14, 8'h1A, 8'hC7, 8'h40, 8'h41, 8'h42,
      8'h43, 8'h44};
   wire logic [3:0] ctl = {hostPin.ale, hostPin.rdN, hostPin.wrN, hostPin.csN};
   logic [2:0]      upCnt_ff;

   // cycles since reset release or stall, saturating
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) upCnt_ff <= 3'h0;
      else if (!ce) upCnt_ff <= 3'h0;
      else if (upCnt_ff != 3'h6) upCnt_ff <= upCnt_ff + 3'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
      else $error("access phase not answered after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == '0)
      else $error("unmapped index not refused");
   a_ok_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped index refused");
   a_read_lane: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bytes not zero");
   a_portd_width: assert property (pready && !pwrite && isD |-> prdata[7:3] == 5'h00)
      else $error("port d register wider than three pins");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   a_pin_sync: assert property (upCnt_ff == 3'h6 |-> pinToLogic == $past(pinIn, 2))
      else $error("pin levels not forwarded to logic arrays");
   a_ctrl_fwd: assert property (upCnt_ff == 3'h6 |-> hostCtrlToLogic == $past(ctl, 3))
      else $error("host control not forwarded to logic arrays");

   cover property (pready && pslverr);
   cover property (pready && pwrite && mapped);
   cover property ($fell(ctl[0]));
endmodule // pmx_port_mux_checker

bind pmx_port_mux pmx_port_mux_checker i_pmx_port_mux_checker (.clk, .rst_n, .ce, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .hostPin, .hostCtrlToLogic, .pinIn,
   .pinToLogic);

// File: verif/pmx_port_mux_tb_top.sv
module pmx_port_mux_tb_top
   import pmx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             ce = 1'b1;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [9:0]       paddr = '0;
   logic [31:0]      pwdata = '0;
   logic [3:0]       pstrb = '0;
   logic [26:0]      pinIn = '0;
   logic [26:0]      logicOut = '0;
   logic [26:0]      logicOe = '0;
   logic [3:0]       tst = '0;
   wire logic [31:0] prdata;
   wire logic [7:0]  hostPortData;
   wire logic        pready, pslverr, testTms, testTck, testTdi;
   wire logic [26:0] pinOut, pinOeN, pinToLogic;
   pmx_host_bus_t    hostPin;
   pmx_host_ctrl_t   hostCtrlToLogic;
   int               n_mismatch = 0;
   int               tests_run = 0;
   int               cyc = 0;
   logic [32:0]      r;
   logic [7:0]       d;
   logic [15:0]      a;
   logic [31:0]      e, m, pv;
   logic [7:0]       rwi[$] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h12, 8'h13, 8'h06, 8'h07,
      8'h14, 8'h15, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'hC7};
   logic [7:0]       doutI[4] = '{8'h04, 8'h05, 8'h12, 8'h13};
   logic [7:0]       dirI[4] = '{8'h06, 8'h07, 8'h14, 8'h15};
   logic [7:0]       dinI[4] = '{8'h00, 8'h01, 8'h10, 8'h11};
   logic [7:0]       oenI[4] = '{8'h0C, 8'h0D, 8'h1A, 8'h1B};

   pmx_host_model i_pmx_host_model (.clk(clk), .hostPin(hostPin));
   pmx_port_mux i_pmx_port_mux (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .hostPin, .hostCtrlToLogic, .hostPortData, .pinIn,
      .pinOut, .pinOeN, .logicOut, .logicOe, .pinToLogic, .testStatus(tst[0]),
      .testError(tst[1]), .testTdo(tst[2]), .testTdoOe(tst[3]), .testTms, .testTck, .testTdi);

   initial forever #2 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk_pin(input logic [26:0] got, input logic [26:0] exp, input logic [26:0] msk);
      tests_run++;
      if ((got & msk) !== (exp & msk)) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
      end
   endtask

   task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h00_0000, v};
      pstrb <= 4'h1;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      apb(1'b1, i, v);
   endtask

   task automatic rd(input logic [7:0] i, input logic [32:0] x);
      apb(1'b0, i, 8'h00);
      chk_reg(r, x);
   endtask

   function automatic logic [7:0] wm(input logic [7:0] i);
      if (i == 8'hC7) return 8'h01;
      return (i inside {8'h13, 8'h15, 8'h43, 8'h44}) ? 8'h07 : 8'hFF;
   endfunction

   initial begin
      void'($urandom(32'h5c30));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rwi[k]) begin
         rd(rwi[k], '0);
         d = $urandom;
         wr(rwi[k], d);
         rd(rwi[k], {25'h0, d & wm(rwi[k])});
         wr(rwi[k], 8'h00);
      end
      rd(8'h08, {1'b1, 32'h0000_0000});
      wr(8'h0C, 8'hFF);
      rd(8'h0C, '0);
      // host i/o on every port
      pv = $urandom;
      pinIn <= pv[26:0];
      for (int p = 0; p < 4; p++) begin
         d = $urandom;
         wr(doutI[p], d);
         e[p*8 +: 8] = d;
         d = $urandom;
         wr(dirI[p], d);
         m[p*8 +: 8] = d & ((p == 3) ? 8'h07 : 8'hFF);
      end
      repeat (4) @(posedge clk);
      chk_pin(pinOut, e[26:0], m[26:0]);
      chk_pin(pinOeN, ~m[26:0], '1);
      chk_pin(hostPortData, pv[7:0], 27'h000_00FF);
      for (int p = 0; p < 4; p++) begin
         rd(dinI[p], {25'h0, pv[p*8 +: 8] & ((p == 3) ? 8'h07 : 8'hFF)});
         rd(oenI[p], {25'h0, m[p*8 +: 8]});
         wr(dirI[p], 8'h00);
      end
      // clock enable low freezes the pin path
      ce <= 1'b0;
      pinIn <= ~pv[26:0];
      repeat (4) @(posedge clk);
      chk_pin(pinToLogic, pv[26:0], '1);
      ce <= 1'b1;
      // logic arrays own every pin
      logicOut <= 27'($urandom);
      logicOe <= 27'($urandom);
      for (int p = 0; p < 4; p++) wr(8'h40 + 8'(p), 8'hFF);
      repeat (3) @(posedge clk);
      chk_pin(pinOut, logicOut, logicOe);
      chk_pin(pinOeN, ~logicOe, '1);
      // test port over logic selection
      tst <= 4'($urandom) | 4'h8;
      pinIn <= 27'($urandom);
      wr(8'hC7, 8'h01);
      repeat (5) @(posedge clk);
      e = {5'h0, logicOut};
      m = {5'h0, logicOe};
      {e[22], e[20], e[19]} = {tst[2], tst[1], tst[0]};
      {m[22], m[21], m[20], m[19], m[17], m[16]} = 6'b101100;
      chk_pin(pinOut, e[26:0], m[26:0]);
      chk_pin(pinOeN, ~m[26:0], '1);
      chk_pin({testTdi, 3'h0, testTck, testTms, 16'h0000}, pinIn, 27'h023_0000);
      wr(8'hC7, 8'h00);
      for (int p = 0; p < 4; p++) wr(8'h40 + 8'(p), 8'h00);
      // latched address per host profile
      wr(8'h02, 8'hFF);
      wr(8'h03, 8'hFF);
      for (int p = 0; p < 4; p++) begin
         wr(8'h44, 8'(p));
         a = $urandom;
         i_pmx_host_model.latch_addr(a);
         repeat (6) @(posedge clk);
         if (p == 1) a = ~a;
         e = '0;
         m = '0;
         case (p)
            0: {e[15:0], m[15:0]} = {a[7:0], a[7:0], 16'hFFFF};
            1: {e[15:8], m[15:8]} = {a[7:0], 8'hFF};
            2: {e[11:4], m[15:0]} = {a[11:8], a[7:4], 16'h0FF0};
            default: {e[15:8], m[15:8]} = {a[15:8], 8'hFF};
         endcase
         chk_pin(pinOut, e[26:0], m[26:0]);
         chk_pin(pinOeN, ~m[26:0], 27'h000_FFFF);
      end
      // data port on a non-multiplexed bus
      wr(8'h44, 8'h05);
      d = $urandom;
      i_pmx_host_model.bus_write(1'b1, d);
      repeat (6) @(posedge clk);
      chk_pin(pinOut, {19'h0, d}, 27'h000_00FF);
      chk_pin(pinOeN, '0, 27'h000_00FF);
      chk_reg(hostCtrlToLogic, 33'h4);
      i_pmx_host_model.bus_write(1'b0, d);
      repeat (6) @(posedge clk);
      chk_pin(pinOeN, '1, 27'h000_00FF);
      chk_reg(hostCtrlToLogic, 33'h7);
      // reset in mid-run
      rst_n <= 1'b0;
      @(posedge clk);
      chk_pin(pinOeN, '1, '1);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h44, '0);
      stop_test();
   end
endmodule // pmx_port_mux_tb_top
